/* File: hdl/mem_port_pkg.sv */
// shared constants and types for the dual bank byte memory port controller
package mem_port_pkg;

   // ==================================================================
   // pin, timer and cycle counter widths
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int SMALL_SRAM_AW = 17;   // bank 0 small sram decodes only these bits
   localparam int TMR_W = 32;
   localparam int CNT_W = 8;

   // ==================================================================
   // user command codes
   typedef logic [1:0] op_t;
   localparam op_t OP_READ = 2'h0;
   localparam op_t OP_WRITE = 2'h1;
   localparam op_t OP_ERASE = 2'h2;
   localparam op_t OP_PROGRAM = 2'h3;

   // board fit codes
   typedef logic [1:0] board_cfg_t;
   localparam board_cfg_t CFG_SMALL_SRAM_WITH_FLASH = 2'h0;
   localparam board_cfg_t CFG_LARGE_SRAM_WITH_FLASH = 2'h1;
   localparam board_cfg_t CFG_DUAL_SRAM = 2'h2;

   // bank numbers
   localparam logic BANK0 = 1'b0;
   localparam logic BANK1 = 1'b1;

   // ==================================================================
   // flash command bytes and status layout
   localparam logic [7:0] FL_ERASE_SETUP = 8'h20;
   localparam logic [7:0] FL_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] FL_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] FL_READ_ARRAY = 8'hff;
   localparam logic [7:0] FL_ERASED = 8'hff;
   localparam logic [7:0] FL_FAIL_MASK = 8'h38;
   localparam int FL_READY_BIT = 7;

   // ==================================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int T_SETUP_NS = 10;
   localparam int T_STROBE_NS = 70;
   localparam int T_HOLD_NS = 10;
   localparam int ERASE_TIMEOUT_US = 20000;
   localparam int PROGRAM_TIMEOUT_US = 1000;

   // least time in ns to whole cycles, never below one
   function automatic int ceil_cycles(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ceil_cycles

   localparam int SETUP_CYC = ceil_cycles(T_SETUP_NS);
   localparam int STROBE_CYC = ceil_cycles(T_STROBE_NS);
   localparam int HOLD_CYC = ceil_cycles(T_HOLD_NS);
   localparam int ERASE_TIMEOUT_CYC = ERASE_TIMEOUT_US * CLK_MHZ;
   localparam int PROGRAM_TIMEOUT_CYC = PROGRAM_TIMEOUT_US * CLK_MHZ;

endpackage : mem_port_pkg

/* File: hdl/mem_cycle_if.sv */
// carrier between sequencer and pin cycle engine
`timescale 1ns/1ps
interface mem_cycle_if;
   import mem_port_pkg::*;
   logic req;
   logic we;
   logic bank;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output req, output we, output bank, output addr, output wdata, input done, input rdata);
   modport eng (input req, input we, input bank, input addr, input wdata, output done, output rdata);
endinterface : mem_cycle_if

/* File: hdl/wait_timer.sv */
// down counter that bounds a status polling loop
`timescale 1ns/1ps
module wait_timer #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic start_i,
   input wire logic [W-1:0] load_i,
   // status
   output logic expired_o
);
   import mem_port_pkg::*;

   logic [W-1:0] cnt_r;
   logic run_r;

   // ==================================================================
   // count down while running; expiry is a level until restarted
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_r <= load_i;
         run_r <= 1'b1;
      end
      else if (run_r && cnt_r != '0)
      begin
         cnt_r <= cnt_r - W'(1);
      end
   end

   assign expired_o = run_r && (cnt_r == '0);

endmodule : wait_timer

/* File: hdl/mem_cycle_engine.sv */
// one asynchronous read or write cycle on the board pins
`timescale 1ns/1ps
module mem_cycle_engine (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // sequencer side
   mem_cycle_if.eng cyc,
   // board pins
   output logic [mem_port_pkg::ADDR_W-1:0] byte_address_o,
   output logic bank0_select_n_o,
   output logic bank1_select_n_o,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   input wire logic [mem_port_pkg::DATA_W-1:0] data_bus_i,
   output logic [mem_port_pkg::DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_n_o
);
   import mem_port_pkg::*;

   typedef enum logic [3:0] {
      E_IDLE = 4'b0001,
      E_SETUP = 4'b0010,
      E_STROBE = 4'b0100,
      E_HOLD = 4'b1000
   } eng_state_t;

   eng_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic we_r;
   logic done_r;
   logic [DATA_W-1:0] rdata_r;

   // ==================================================================
   // phase sequencer; every pin is a flip-flop so nothing glitches
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= E_IDLE;
         cnt_r <= '0;
         we_r <= 1'b0;
         done_r <= 1'b0;
         rdata_r <= '0;
         byte_address_o <= '0;
         bank0_select_n_o <= 1'b1;
         bank1_select_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         data_bus_o <= '0;
         data_bus_oe_n_o <= 1'b1;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            E_IDLE:
            begin
               if (cyc.req)
               begin
                  byte_address_o <= cyc.addr;
                  we_r <= cyc.we;
                  bank0_select_n_o <= !(cyc.bank == BANK0);
                  bank1_select_n_o <= !(cyc.bank == BANK1);
                  data_bus_o <= cyc.wdata;
                  data_bus_oe_n_o <= !cyc.we;
                  cnt_r <= CNT_W'(SETUP_CYC - 1);
                  state_r <= E_SETUP;
               end
            end
            E_SETUP:
            begin
               if (cnt_r == '0)
               begin
                  read_strobe_n_o <= we_r;
                  write_strobe_n_o <= !we_r;
                  cnt_r <= CNT_W'(STROBE_CYC - 1);
                  state_r <= E_STROBE;
               end
               else
               begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            E_STROBE:
            begin
               if (cnt_r == '0)
               begin
                  // byte off shared bus
                  // capture while read strobe still low
                  if (!we_r)
                  begin
                     rdata_r <= data_bus_i;
                  end
                  read_strobe_n_o <= 1'b1;
                  write_strobe_n_o <= 1'b1;
                  cnt_r <= CNT_W'(HOLD_CYC - 1);
                  state_r <= E_HOLD;
               end
               else
               begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            E_HOLD:
            begin
               if (cnt_r == '0)
               begin
                  // data held past the strobe edge, then all released
                  bank0_select_n_o <= 1'b1;
                  bank1_select_n_o <= 1'b1;
                  data_bus_oe_n_o <= 1'b1;
                  done_r <= 1'b1;
                  state_r <= E_IDLE;
               end
               else
               begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end
            end
            default:
            begin
               state_r <= E_IDLE;
            end
         endcase
      end
   end

   assign cyc.done = done_r;
   assign cyc.rdata = rdata_r;

endmodule : mem_cycle_engine

/* File: hdl/mem_port_ctrl.sv */
// host controller for the dual bank byte memory board
//
// Behaviour
// - bank 0 is reached only by pulling its select low.
// - bank 1, sram or flash, is reached by pulling its select low.
// - nineteen address bits and one shared eight bit two way data bus.
// - read: address, select low, read strobe low, then capture the byte.
// - write: address and data set up, select low, before the write strobe.
// - write strobe goes low then high; the byte is stored on that pulse.
// - dual sram fit has no flash; bank 1 is plain sram.
// - flash reads use the same sequence as sram reads.
// - a block is erased before any location in it is programmed; the code only checks that the byte itself reads all ones.
// - only program bytes that currently read all ones.
// - erase sequence is sent to any address inside the block.
// - after erase, poll status until done before the next sequence; the code also stops polling when ERASE_TIMEOUT runs out.
// - program sequence is sent to the byte's own address.
// - after program, poll status until done before the next program; the code also stops polling when PROGRAM_TIMEOUT runs out.
`timescale 1ns/1ps
module mem_port_ctrl #(
   parameter int ERASE_TIMEOUT = mem_port_pkg::ERASE_TIMEOUT_CYC,
   parameter int PROGRAM_TIMEOUT = mem_port_pkg::PROGRAM_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // board fit strap
   input wire mem_port_pkg::board_cfg_t board_cfg_i,
   // user command
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire mem_port_pkg::op_t cmd_op_i,
   input wire logic cmd_bank_i,
   input wire logic [mem_port_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [mem_port_pkg::DATA_W-1:0] cmd_wdata_i,
   // user response
   output logic rsp_valid_o,
   output logic [mem_port_pkg::DATA_W-1:0] rsp_rdata_o,
   output logic rsp_err_o,
   // board pins
   output logic [mem_port_pkg::ADDR_W-1:0] byte_address_o,
   output logic bank0_select_n_o,
   output logic bank1_select_n_o,
   output logic read_strobe_n_o,
   output logic write_strobe_n_o,
   input wire logic [mem_port_pkg::DATA_W-1:0] data_bus_i,
   output logic [mem_port_pkg::DATA_W-1:0] data_bus_o,
   output logic data_bus_oe_n_o
);
   import mem_port_pkg::*;

   // ==================================================================
   // sequencer states
   typedef enum logic [7:0] {
      S_IDLE = 8'b0000_0001,
      S_ACCESS = 8'b0000_0010,
      S_PRECHK = 8'b0000_0100,
      S_CMD1 = 8'b0000_1000,
      S_CMD2 = 8'b0001_0000,
      S_POLL = 8'b0010_0000,
      S_RESTORE = 8'b0100_0000,
      S_RESP = 8'b1000_0000
   } seq_state_t;

   seq_state_t state_r;
   logic rst_meta_r;
   logic rst_sync_n_r;
   op_t op_r;
   logic bank_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic busy_r;
   logic rsp_valid_r;
   logic [DATA_W-1:0] rsp_rdata_r;
   logic rsp_err_r;
   logic tmr_start;
   logic [TMR_W-1:0] tmr_load;
   logic tmr_expired;
   logic cycle_state;
   logic flash_fitted;
   logic [ADDR_W-1:0] eff_addr;

   mem_cycle_if cyc ();

   // ==================================================================
   // reset release through two flip-flops
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   // ==================================================================
   // decode helpers

   // flash only in the two flash fits
   assign flash_fitted = (board_cfg_i != CFG_DUAL_SRAM);

   // upper bits are dropped rather than left floating on the small part
   always_comb
   begin
      eff_addr = cmd_addr_i;
      if (board_cfg_i == CFG_SMALL_SRAM_WITH_FLASH && cmd_bank_i == BANK0)
      begin
         eff_addr[ADDR_W-1:SMALL_SRAM_AW] = '0;
      end
   end

   // flash operations only make sense on bank 1 with flash fitted
   function automatic logic flash_op_ok(input op_t op, input logic bank, input logic fitted);
      return (op == OP_ERASE || op == OP_PROGRAM) ? (bank == BANK1 && fitted) : 1'b1;
   endfunction : flash_op_ok

   assign cmd_ready_o = (state_r == S_IDLE) && rst_sync_n_r;

   // ==================================================================
   // cycle request to the pin engine; one cycle in flight at a time
   assign cycle_state = (state_r == S_ACCESS) || (state_r == S_PRECHK) || (state_r == S_CMD1)
                        || (state_r == S_CMD2) || (state_r == S_POLL) || (state_r == S_RESTORE);
   assign cyc.req = cycle_state && !busy_r;
   assign cyc.bank = bank_r;
   assign cyc.addr = addr_r;

   // per state choice of direction and written byte
   always_comb
   begin
      cyc.we = 1'b0;
      cyc.wdata = '0;
      case (state_r)
         S_ACCESS:
         begin
            // flash read is a plain read
            cyc.we = (op_r == OP_WRITE);
            cyc.wdata = wdata_r;
         end
         S_CMD1:
         begin
            cyc.we = 1'b1;
            cyc.wdata = (op_r == OP_ERASE) ? FL_ERASE_SETUP : FL_PROGRAM_SETUP;
         end
         S_CMD2:
         begin
            cyc.we = 1'b1;
            cyc.wdata = (op_r == OP_ERASE) ? FL_ERASE_CONFIRM : wdata_r;
         end
         S_RESTORE:
         begin
            cyc.we = 1'b1;
            cyc.wdata = FL_READ_ARRAY;
         end
         default:
         begin
            cyc.we = 1'b0;
            cyc.wdata = '0;
         end
      endcase
   end

   // in flight flag, cleared by the engine's done pulse
   always_ff @(posedge clk_i or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         busy_r <= 1'b0;
      end
      else if (cyc.done)
      begin
         busy_r <= 1'b0;
      end
      else if (cyc.req)
      begin
         busy_r <= 1'b1;
      end
   end

   // ==================================================================
   // status poll timeout; bounds a dead or absent flash
   always_comb
   begin
      tmr_start = 1'b0;
      tmr_load = '0;
      if (state_r == S_CMD2 && cyc.done)
      begin
         tmr_start = 1'b1;
         tmr_load = (op_r == OP_ERASE) ? TMR_W'(ERASE_TIMEOUT) : TMR_W'(PROGRAM_TIMEOUT);
      end
   end

   wait_timer #(
      .W(TMR_W)
   ) u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_sync_n_r),
      .start_i(tmr_start),
      .load_i(tmr_load),
      .expired_o(tmr_expired)
   );

   // ==================================================================
   // command sequencer
   always_ff @(posedge clk_i or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         state_r <= S_IDLE;
         op_r <= OP_READ;
         bank_r <= BANK0;
         addr_r <= '0;
         wdata_r <= '0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               if (cmd_valid_i)
               begin
                  op_r <= cmd_op_i;
                  bank_r <= cmd_bank_i;
                  addr_r <= eff_addr;
                  wdata_r <= cmd_wdata_i;
                  if (!flash_op_ok(cmd_op_i, cmd_bank_i, flash_fitted))
                  begin
                     state_r <= S_RESP;
                  end
                  else if (cmd_op_i == OP_PROGRAM)
                  begin
                     state_r <= S_PRECHK;
                  end
                  else if (cmd_op_i == OP_ERASE)
                  begin
                     state_r <= S_CMD1;
                  end
                  else
                  begin
                     state_r <= S_ACCESS;
                  end
               end
            end
            S_ACCESS:
            begin
               if (cyc.done)
               begin
                  state_r <= S_RESP;
               end
            end
            S_PRECHK:
            begin
               if (cyc.done)
               begin
                  state_r <= (cyc.rdata == FL_ERASED) ? S_CMD1 : S_RESP;
               end
            end
            S_CMD1:
            begin
               if (cyc.done)
               begin
                  state_r <= S_CMD2;
               end
            end
            S_CMD2:
            begin
               if (cyc.done)
               begin
                  state_r <= S_POLL;
               end
            end
            S_POLL:
            begin
               if (cyc.done && (cyc.rdata[FL_READY_BIT] || tmr_expired))
               begin
                  state_r <= S_RESTORE;
               end
            end
            S_RESTORE:
            begin
               if (cyc.done)
               begin
                  state_r <= S_RESP;
               end
            end
            S_RESP:
            begin
               state_r <= S_IDLE;
            end
            default:
            begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // response: one cycle pulse while in S_RESP
   always_ff @(posedge clk_i or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= '0;
         rsp_err_r <= 1'b0;
      end
      else
      begin
         rsp_valid_r <= 1'b0;
         if (state_r == S_IDLE && cmd_valid_i)
         begin
            rsp_err_r <= !flash_op_ok(cmd_op_i, cmd_bank_i, flash_fitted);
            rsp_rdata_r <= '0;
            rsp_valid_r <= !flash_op_ok(cmd_op_i, cmd_bank_i, flash_fitted);
         end
         else if (state_r == S_ACCESS && cyc.done)
         begin
            rsp_rdata_r <= cyc.rdata;
            rsp_valid_r <= 1'b1;
         end
         else if (state_r == S_PRECHK && cyc.done && cyc.rdata != FL_ERASED)
         begin
            rsp_rdata_r <= cyc.rdata;
            rsp_err_r <= 1'b1;
            rsp_valid_r <= 1'b1;
         end
         else if (state_r == S_POLL && cyc.done)
         begin
            // final status kept for the user
            rsp_rdata_r <= cyc.rdata;
            rsp_err_r <= !cyc.rdata[FL_READY_BIT] || ((cyc.rdata & FL_FAIL_MASK) != '0);
         end
         else if (state_r == S_RESTORE && cyc.done)
         begin
            rsp_valid_r <= 1'b1;
         end
      end
   end

   assign rsp_valid_o = rsp_valid_r;
   assign rsp_rdata_o = rsp_rdata_r;
   assign rsp_err_o = rsp_err_r;

   // ==================================================================
   // pin engine; owns every board pin
   // one select at a time
   mem_cycle_engine u_engine (
      .clk_i(clk_i),
      .rst_n_i(rst_sync_n_r),
      .cyc(cyc),
      .byte_address_o(byte_address_o),
      .bank0_select_n_o(bank0_select_n_o),
      .bank1_select_n_o(bank1_select_n_o),
      .read_strobe_n_o(read_strobe_n_o),
      .write_strobe_n_o(write_strobe_n_o),
      .data_bus_i(data_bus_i),
      .data_bus_o(data_bus_o),
      .data_bus_oe_n_o(data_bus_oe_n_o)
   );

endmodule : mem_port_ctrl

/* File: verif/mem_port_checker_properties.sv */
// pin level properties of the memory port controller
`timescale 1ns/1ps
module mem_port_checker
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // user side
   input wire mem_port_pkg::board_cfg_t board_cfg_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire mem_port_pkg::op_t cmd_op_i,
   input wire logic cmd_bank_i,
   input wire logic rsp_valid_o,
   input wire logic rsp_err_o,
   // board pins
   input wire logic [18:0] byte_address_o,
   input wire logic bank0_select_n_o,
   input wire logic bank1_select_n_o,
   input wire logic read_strobe_n_o,
   input wire logic write_strobe_n_o,
   input wire logic [7:0] data_bus_o,
   input wire logic data_bus_oe_n_o
);
   import mem_port_pkg::*;
   wire take = cmd_valid_i && cmd_ready_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   one_select_a: assert property (bank0_select_n_o || bank1_select_n_o)
      else $error("both bank selects low");
   rd_no_drive_a: assert property (!read_strobe_n_o |-> data_bus_oe_n_o)
      else $error("bus driven during read");
   wr_drive_a: assert property (!write_strobe_n_o
      |-> !data_bus_oe_n_o && !(bank0_select_n_o && bank1_select_n_o))
      else $error("write strobe without data or select");
   rd_order_a: assert property ($fell(read_strobe_n_o) |-> !$past(bank0_select_n_o) || !$past(bank1_select_n_o))
      else $error("read strobe before select");
   rd_len_a: assert property ($fell(read_strobe_n_o) |-> (!read_strobe_n_o && $stable(byte_address_o))[*7]
      ##1 read_strobe_n_o)
      else $error("read strobe length wrong");
   wr_pulse_a: assert property ($fell(write_strobe_n_o) |-> ($stable(data_bus_o) && !data_bus_oe_n_o)[*7]
      ##1 write_strobe_n_o)
      else $error("write pulse wrong");
   small_addr_a: assert property (!bank0_select_n_o && board_cfg_i == CFG_SMALL_SRAM_WITH_FLASH
      |-> byte_address_o[18:17] == 2'h0)
      else $error("small sram high address bits set");
   refuse_a: assert property (take && cmd_op_i[1] && (!cmd_bank_i || board_cfg_i == CFG_DUAL_SRAM)
      |-> ##1 rsp_valid_o && rsp_err_o)
      else $error("flash command not refused");
   rsp_read_a: assert property (take && !cmd_op_i[1] |-> ##12 rsp_valid_o && !rsp_err_o)
      else $error("read or write answer late");
endmodule : mem_port_checker

bind mem_port_ctrl mem_port_checker mem_port_checker_inst (.clk_i, .rst_n_i, .board_cfg_i, .cmd_valid_i,
   .cmd_ready_o, .cmd_op_i, .cmd_bank_i, .rsp_valid_o, .rsp_err_o, .byte_address_o, .bank0_select_n_o,
   .bank1_select_n_o, .read_strobe_n_o, .write_strobe_n_o, .data_bus_o, .data_bus_oe_n_o);

/* File: verif/mem_board_model.sv */
// behavioural memory board: sram bank 0, sram or flash bank 1
`timescale 1ns/1ps
module mem_board_model
(
   // board pins
   input wire mem_port_pkg::board_cfg_t cfg_i,
   input wire logic [18:0] addr_i,
   input wire logic cs0_n_i,
   input wire logic cs1_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [7:0] d_i,
   output logic [7:0] q_o
);
   import mem_port_pkg::*;
   logic [7:0] m0 [int];
   logic [7:0] m1 [int];
   int mode = 0;
   int busy = 0;
   logic flip = 1'b0;
   wire fl = cfg_i != CFG_DUAL_SRAM;
   wire [18:0] a0 = (cfg_i == CFG_SMALL_SRAM_WITH_FLASH) ? {2'h0, addr_i[16:0]} : addr_i;
   // three small blocks, the third also covering 0x8000-0xffff, then 64k ones
   function automatic int blk(input int a);
      return (a < 'h4000) ? 0 : (a < 'h6000) ? 1 : (a < 'h8000) ? 2 : 2 + a / 'h10000;
   endfunction : blk
   // released bus keeps changing, no pull resistors
   always #7 flip = ~flip;
   always @*
   begin
      if (!oe_n_i && !cs0_n_i)
         q_o = m0.exists(a0) ? m0[a0] : 8'h00;
      else if (!oe_n_i && !cs1_n_i && fl && mode == 3)
         q_o = {busy == 0, 7'h00};
      else if (!oe_n_i && !cs1_n_i)
         q_o = m1.exists(addr_i) ? m1[addr_i] : (fl ? FL_ERASED : 8'h00);
      else
         q_o = {8{flip}} ^ 8'ha5;
   end
   // status polls count down a slow device
   always @(posedge oe_n_i)
   begin
      if (!cs1_n_i && busy > 0)
         busy--;
   end
   always @(posedge we_n_i)
   begin
      if (!cs0_n_i)
         m0[a0] = d_i;
      else if (!cs1_n_i && !fl)
         m1[addr_i] = d_i;
      else if (!cs1_n_i && mode == 2)
      begin
         m1[addr_i] = (m1.exists(addr_i) ? m1[addr_i] : FL_ERASED) & d_i;
         mode = 3;
         busy = 2;
      end
      else if (!cs1_n_i && mode == 1 && d_i == FL_ERASE_CONFIRM)
      begin
         foreach (m1[k])
            if (blk(k) == blk(addr_i))
               m1[k] = FL_ERASED;
         mode = 3;
         busy = 4;
      end
      else if (!cs1_n_i)
         mode = (d_i == FL_ERASE_SETUP) ? 1 : (d_i == FL_PROGRAM_SETUP) ? 2 : (d_i == FL_READ_ARRAY) ? 0 : mode;
   end
endmodule : mem_board_model

/* File: verif/testbench.sv */
// self checking bench for the memory port controller
`timescale 1ns/1ps
module testbench;
   import mem_port_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   board_cfg_t cfg = CFG_DUAL_SRAM;
   logic v = 1'b0;
   op_t op = OP_READ;
   logic bk = 1'b0;
   logic [18:0] ad = 19'h0;
   logic [7:0] wd = 8'h00;
   logic [8:0] r;
   wire ready, rv, rerr, c0, c1, oe, we, oen;
   wire [7:0] rd, dq, q;
   wire [18:0] pa;
   // controller wins the bus only while its enable is low
   wire [7:0] bus = !oen ? dq : q;
   int err_count = 0;
   int check_count = 0;

   mem_port_ctrl #(.ERASE_TIMEOUT(200), .PROGRAM_TIMEOUT(50)) mem_port_ctrl_inst (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .board_cfg_i(cfg), .cmd_valid_i(v), .cmd_ready_o(ready), .cmd_op_i(op),
      .cmd_bank_i(bk), .cmd_addr_i(ad), .cmd_wdata_i(wd), .rsp_valid_o(rv), .rsp_rdata_o(rd),
      .rsp_err_o(rerr), .byte_address_o(pa), .bank0_select_n_o(c0), .bank1_select_n_o(c1),
      .read_strobe_n_o(oe), .write_strobe_n_o(we), .data_bus_i(bus), .data_bus_o(dq), .data_bus_oe_n_o(oen));
   mem_board_model mem_board_model_inst (.cfg_i(cfg), .addr_i(pa), .cs0_n_i(c0), .cs1_n_i(c1), .oe_n_i(oe),
      .we_n_i(we), .d_i(bus), .q_o(q));

   initial forever #5 clk_i = ~clk_i;

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one command, answer as {err, data}
   task automatic cmd(input op_t o, input logic b, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(negedge clk_i);
      while (ready !== 1'b1)
         @(negedge clk_i);
      v = 1'b1;
      op = o;
      bk = b;
      ad = a;
      wd = d;
      @(negedge clk_i);
      v = 1'b0;
      n = 0;
      while (rv !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      // a lost answer counts as a mismatch
      if (n >= 3000)
         err_count++;
      r = {rerr, rd};
   endtask : cmd

   // both banks plain sram, flash erase refused
   task automatic t_dual();
      cfg = CFG_DUAL_SRAM;
      cmd(OP_WRITE, BANK0, 19'h7ffff, 8'h3c);
      cmd(OP_WRITE, BANK1, 19'h7ffff, 8'hc3);
      cmd(OP_READ, BANK0, 19'h7ffff, 8'h00);
      check("bank0", r, 9'h03c);
      cmd(OP_READ, BANK1, 19'h7ffff, 8'h00);
      check("bank1", r, 9'h0c3);
      cmd(OP_ERASE, BANK1, 19'h00000, 8'h00);
      check("dual erase", {r[8], 8'h00}, 9'h100);
   endtask : t_dual

   // small sram aliases the top address bits
   task automatic t_small();
      cfg = CFG_SMALL_SRAM_WITH_FLASH;
      cmd(OP_WRITE, BANK0, 19'h60012, 8'h5a);
      cmd(OP_READ, BANK0, 19'h00012, 8'h00);
      check("alias", r, 9'h05a);
      cmd(OP_PROGRAM, BANK0, 19'h00012, 8'h00);
      check("bank0 program", {r[8], 8'h00}, 9'h100);
   endtask : t_small

   // erase, program, overprogram, block bounds
   task automatic t_flash();
      cfg = CFG_LARGE_SRAM_WITH_FLASH;
      cmd(OP_PROGRAM, BANK1, 19'h03fff, 8'h77);
      check("prog blk0", r[8], 1'b0);
      cmd(OP_ERASE, BANK1, 19'h05000, 8'h00);
      check("erase", r[8], 1'b0);
      cmd(OP_PROGRAM, BANK1, 19'h04001, 8'h12);
      check("prog", r[8], 1'b0);
      cmd(OP_READ, BANK1, 19'h04001, 8'h00);
      check("flash read", r, 9'h012);
      cmd(OP_PROGRAM, BANK1, 19'h04001, 8'h34);
      check("overprogram", {r[8], 8'h00}, 9'h100);
      cmd(OP_ERASE, BANK1, 19'h05fff, 8'h00);
      cmd(OP_READ, BANK1, 19'h04001, 8'h00);
      check("erased", r, 9'h0ff);
      cmd(OP_READ, BANK1, 19'h03fff, 8'h00);
      check("other block", r, 9'h077);
   endtask : t_flash

   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // main sequence
   initial
   begin
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_dual();
      t_small();
      t_flash();
      stop_test();
   end

   // hang guard, far beyond the sixteen short commands
   initial
   begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule : testbench
